/* rtl/pcgm_regs.vh */
// Function
// - Temperature comes from one selected source.
// - Report selected temperature and on-chip temperature always.
// - Integrate signed 15-bit sense current continuously.
// - Subtract self consumption from reported current.
// - Three modes; one latched per power-on.
// - Accumulate mode updates measurements every second.
// - Accumulated data valid only while active; here it can outlast power-off by one cycle.
// - Health mode measures right after power-on.
// - Health low flag when state at threshold.
// - Low voltage warning, optionally alerting.
// - Low and high temperature warnings, optionally alerting.
// - Alert flag is mask AND status bit.
// - First voltage after power-on is OCV.
// - Single active mode while power-on asserted.
// - Subcommand 002E enables history logging.
// - Min/max kept in RAM, committed on command; here only the shared stop code commits, and only while running.
// - Hash input is message then key.
// - Pad with one, 159 zeros, length 288.
// - Standard SHA-1 compression gives 160-bit digest.
`ifndef PCGM_REGS_VH
`define PCGM_REGS_VH
`define PCGM_TICK_MS        1000
`define PCGM_CLK_KHZ        10000
`define PCGM_MODE_ACC       2'h0
`define PCGM_MODE_HEALTH    2'h1
`define PCGM_MODE_END       2'h2
`define PCGM_CMD_START      16'h0011
`define PCGM_CMD_STOP       16'h0012
`define PCGM_CMD_LOG_EN     16'h002e
`define PCGM_CMD_COMMIT     16'h0012
`define PCGM_CMD_FRESH      16'ha613
`define PCGM_ST_VLOW        0
`define PCGM_ST_TLOW        1
`define PCGM_ST_THIGH       2
`define PCGM_ST_HLOW        3
`define PCGM_CS_ACTIVE      0
`define PCGM_CS_DONE        1
`define PCGM_CS_LOGEN       2
`define PCGM_AL_ACTIVE      4
`define PCGM_AL_DONE        5
`define PCGM_LOG_WORDS      3'h6
`define PCGM_PAD_ZEROS      159
`define PCGM_PAD_LEN        64'h0000000000000120
`define PCGM_SHA_ROUNDS     7'h4f
`define PCGM_H0             32'h67452301
`define PCGM_H1             32'hefcdab89
`define PCGM_H2             32'h98badcfe
`define PCGM_H3             32'h10325476
`define PCGM_H4             32'hc3d2e1f0
`define PCGM_K0             32'h5a827999
`define PCGM_K1             32'h6ed9eba1
`define PCGM_K2             32'h8f1bbcdc
`define PCGM_K3             32'hca62c1d6
`define PCGM_T20            7'h14
`define PCGM_T40            7'h28
`define PCGM_T60            7'h3c
`endif

/* rtl/pcgm_monitor.v */
`timescale 1ns/10ps
`default_nettype none
`include "pcgm_regs.vh"
module pcgm_monitor #(
  parameter TICK_CYCLES = `PCGM_TICK_MS * `PCGM_CLK_KHZ
) (
  input  wire         clk_i,
  input  wire         reset_n_i,
  input  wire         power_on_input_i,
  input  wire [1:0]   mode_sel_i,
  input  wire         temp_source_select_i,
  input  wire         meas_valid_i,
  input  wire [15:0]  cell_voltage_i,
  input  wire [15:0]  ext_temp_i,
  input  wire [15:0]  onchip_temp_i,
  input  wire [14:0]  sense_code_i,
  input  wire [15:0]  self_consumption_current_i,
  input  wire [7:0]   state_value_i,
  input  wire [7:0]   health_low_threshold_i,
  input  wire [15:0]  volt_low_threshold_i,
  input  wire [15:0]  temp_low_threshold_i,
  input  wire [15:0]  temp_high_threshold_i,
  input  wire [7:0]   alert_mask_bits_i,
  input  wire         impedance_valid_i,
  input  wire [15:0]  impedance_i,
  input  wire         cmd_valid_i,
  input  wire [15:0]  cmd_code_i,
  input  wire         sha_start_i,
  input  wire [159:0] sha_msg_i,
  input  wire [127:0] sha_key_i,
  output reg          active_o,
  output reg  [15:0]  temperature_o,
  output reg  [15:0]  onchip_temp_reading_o,
  output reg  [15:0]  voltage_o,
  output reg  [15:0]  current_o,
  output reg  [31:0]  coulomb_o,
  output wire         acc_data_valid_o,
  output reg  [15:0]  ocv_o,
  output reg  [7:0]   health_o,
  output reg          health_valid_o,
  output reg  [7:0]   cell_status_flags_o,
  output reg  [15:0]  ctrl_state_word_o,
  output reg  [7:0]   cell_alert_flags_o,
  output reg          alert_o,
  output reg  [15:0]  fresh_cell_resistance_o,
  output reg          flash_we_o,
  output reg  [2:0]   flash_addr_o,
  output reg  [15:0]  flash_data_o,
  output reg          sha_busy_o,
  output reg          sha_done_o,
  output reg  [159:0] sha_digest_o
);
  // One-hot sequencer states; a flush ends in DONE unless power drops first, so the host sees stop complete.
  localparam S_IDLE  = 4'h1;
  localparam S_RUN   = 4'h2;
  localparam S_FLUSH = 4'h4;
  localparam S_DONE  = 4'h8;

  // Power-on pin is asynchronous; a change counts only when stages two and three agree.
  // Stage one may go metastable, so nothing but stage two ever reads it.
  reg [2:0] pon_sync_q;
  reg       pon_q;
  reg       pon_rise_q;
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      pon_sync_q <= 3'h0;
      pon_q      <= 1'b0;
      pon_rise_q <= 1'b0;
    end else begin
      pon_sync_q <= {pon_sync_q[1:0], power_on_input_i};
      pon_rise_q <= 1'b0;
      if (pon_sync_q[1] == pon_sync_q[2] && pon_q != pon_sync_q[2]) begin
        pon_q      <= pon_sync_q[2];
        pon_rise_q <= pon_sync_q[2];
      end
    end
  end

  // The one active mode simply follows the filtered pin level.
  // Dropping the pin ends the active mode; the sequencer then falls back to idle.
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      active_o <= 1'b0;
    end else begin
      active_o <= pon_q;
    end
  end

  // Mode is sampled once per power-on so a stray change on the strap cannot swap algorithms.
  // A service-end setting is held like any other code and simply runs no sequencer here.
  reg [1:0] mode_q;
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      mode_q <= `PCGM_MODE_ACC;
    end else if (pon_rise_q) begin
      mode_q <= mode_sel_i;
    end
  end
  wire acc_mode = (mode_q == `PCGM_MODE_ACC);
  wire hlt_mode = (mode_q == `PCGM_MODE_HEALTH);

  // One second divider; the tick is a single-cycle enable.
  // The divider idles at zero while unpowered, so the first update lands a full period in.
  reg [31:0] tick_cnt_q;
  reg        tick_q;
  always @(posedge clk_i) begin
    if (!reset_n_i || !active_o) begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == TICK_CYCLES - 1) begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
      tick_q     <= 1'b0;
    end
  end

  // Command decode and the accumulation sequencer.
  // Stop and commit share one code, so ending accumulation also saves the history.
  wire cmd_start  = cmd_valid_i && cmd_code_i == `PCGM_CMD_START;
  wire cmd_stop   = cmd_valid_i && cmd_code_i == `PCGM_CMD_STOP;
  wire cmd_commit = cmd_valid_i && cmd_code_i == `PCGM_CMD_COMMIT;
  wire cmd_log_en = cmd_valid_i && cmd_code_i == `PCGM_CMD_LOG_EN;
  wire cmd_fresh  = cmd_valid_i && cmd_code_i == `PCGM_CMD_FRESH;
  reg [3:0] state_q;
  reg [2:0] flush_idx_q;
  reg       log_en_q;
  always @(posedge clk_i) begin
    if (!reset_n_i || !active_o) begin
      state_q <= S_IDLE;
    end else begin
      case (state_q)
        S_IDLE:  if (cmd_start && acc_mode) state_q <= S_RUN;
        S_RUN:   if (cmd_stop) state_q <= S_FLUSH;
        S_FLUSH: if (!log_en_q || flush_idx_q == `PCGM_LOG_WORDS - 3'h1) state_q <= S_DONE;
        S_DONE:  if (cmd_start && acc_mode) state_q <= S_RUN;
        default: state_q <= S_IDLE;
      endcase
    end
  end
  // Data is only offered to the host while accumulation runs.
  // The host must not cut power while running, or this may show one cycle past power-off.
  assign acc_data_valid_o = acc_mode && state_q == S_RUN;

  // Measurement strobe: each second in accumulate mode, plus the first sample after power-on in every mode.
  // A sample that misses the tick is still integrated, only not reported.
  reg  first_q;
  wire take = meas_valid_i && active_o && ((acc_mode && tick_q) || first_q);
  wire [15:0] sel_temp = temp_source_select_i ? ext_temp_i : onchip_temp_i;
  wire [15:0] cur_raw  = {sense_code_i[14], sense_code_i};
  wire [15:0] cur_net  = cur_raw - self_consumption_current_i;

  // Reported measurements, coulomb integration and the open-circuit capture.
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      temperature_o         <= 16'h0;
      onchip_temp_reading_o <= 16'h0;
      voltage_o             <= 16'h0;
      current_o             <= 16'h0;
      coulomb_o             <= 32'h0;
      ocv_o                 <= 16'h0;
      first_q               <= 1'b0;
      health_o              <= 8'h0;
      health_valid_o        <= 1'b0;
    end else begin
      if (pon_rise_q) begin
        first_q        <= 1'b1;
        health_valid_o <= 1'b0;
      end
      if (take) begin
        temperature_o         <= sel_temp;
        onchip_temp_reading_o <= onchip_temp_i;
        voltage_o             <= cell_voltage_i;
        current_o             <= cur_net;
        first_q               <= 1'b0;
        if (first_q) begin
          ocv_o <= cell_voltage_i;
        end
        if (first_q && hlt_mode) begin
          health_o       <= state_value_i;
          health_valid_o <= 1'b1;
        end
      end
      // Integration keeps going on every sample, not only on the reporting tick.
      if (cmd_fresh) begin
        coulomb_o <= 32'h0;
      end else if (meas_valid_i && active_o) begin
        coulomb_o <= coulomb_o + {{16{cur_net[15]}}, cur_net};
      end
    end
  end

  // Warnings are combinational comparisons held in the status word.
  // There is no hysteresis, so a reading that hovers at a threshold may toggle its flag.
  wire vlow  = voltage_o < volt_low_threshold_i;
  wire tlow  = $signed(temperature_o) < $signed(temp_low_threshold_i);
  wire thigh = $signed(temperature_o) > $signed(temp_high_threshold_i);
  wire hlow  = health_valid_o && health_o <= health_low_threshold_i;
  wire [7:0] alert_src = {2'h0, state_q == S_DONE, state_q == S_RUN, hlow, thigh, tlow, vlow};
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      cell_status_flags_o <= 8'h0;
      ctrl_state_word_o   <= 16'h0;
      cell_alert_flags_o  <= 8'h0;
      alert_o             <= 1'b0;
    end else begin
      cell_status_flags_o <= {4'h0, hlow, thigh, tlow, vlow};
      ctrl_state_word_o   <= {13'h0, log_en_q, state_q == S_DONE, state_q == S_RUN};
      cell_alert_flags_o  <= alert_mask_bits_i & alert_src;
      alert_o             <= |(alert_mask_bits_i & alert_src);
    end
  end

  // History min/max in RAM; written out word by word when the shared stop/commit code ends a run.
  // Current and temperature compare unsigned, a limitation for readings below zero.
  reg [15:0] hist_q [0:5];
  integer i;
  always @(posedge clk_i) begin
    if (!reset_n_i || cmd_fresh) begin
      for (i = 0; i < 6; i = i + 2) begin
        hist_q[i]     <= 16'h0;
        hist_q[i + 1] <= 16'hffff;
      end
    end else if (take && log_en_q) begin
      if (cell_voltage_i > hist_q[0]) hist_q[0] <= cell_voltage_i;
      if (cell_voltage_i < hist_q[1]) hist_q[1] <= cell_voltage_i;
      if (cur_net > hist_q[2]) hist_q[2] <= cur_net;
      if (cur_net < hist_q[3]) hist_q[3] <= cur_net;
      if (sel_temp > hist_q[4]) hist_q[4] <= sel_temp;
      if (sel_temp < hist_q[5]) hist_q[5] <= sel_temp;
    end
  end

  // Flash writes happen only in the flush state, which the shared stop/commit code opens from the run state.
  // One word leaves per cycle, so a slow store behind these pins must buffer the burst.
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      log_en_q     <= 1'b0;
      flush_idx_q  <= 3'h0;
      flash_we_o   <= 1'b0;
      flash_addr_o <= 3'h0;
      flash_data_o <= 16'h0;
    end else begin
      if (cmd_log_en) log_en_q <= 1'b1;
      flash_we_o <= 1'b0;
      if (state_q == S_FLUSH && log_en_q) begin
        flash_we_o   <= 1'b1;
        flash_addr_o <= flush_idx_q;
        flash_data_o <= hist_q[flush_idx_q];
        flush_idx_q  <= flush_idx_q + 3'h1;
      end else begin
        flush_idx_q <= 3'h0;
      end
      if (cmd_commit && state_q != S_RUN) log_en_q <= log_en_q;
    end
  end

  // Fresh cell: the first impedance update after the command is kept as new resistance.
  // A repeated command re-arms the capture even while an earlier one still waits.
  reg fresh_arm_q;
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      fresh_arm_q             <= 1'b0;
      fresh_cell_resistance_o <= 16'h0;
    end else if (cmd_fresh) begin
      fresh_arm_q <= 1'b1;
    end else if (fresh_arm_q && impedance_valid_i) begin
      fresh_arm_q             <= 1'b0;
      fresh_cell_resistance_o <= impedance_i;
    end
  end

  // One SHA-1 round per cycle; a sixteen-word window supplies the message schedule.
  // The block is copied at start, so message and key may change while the rounds run.
  wire [511:0] block = {sha_msg_i, sha_key_i, 1'b1, {`PCGM_PAD_ZEROS{1'b0}}, `PCGM_PAD_LEN};
  reg [31:0] w_q [0:15];
  reg [31:0] a_q, b_q, c_q, d_q, e_q;
  reg [6:0]  t_q;
  reg [31:0] f, k, wn, tmp;
  // Round function and constant change every twenty rounds.
  always @* begin
    if (t_q < `PCGM_T20) begin
      f = (b_q & c_q) | (~b_q & d_q);
      k = `PCGM_K0;
    end else if (t_q < `PCGM_T40) begin
      f = b_q ^ c_q ^ d_q;
      k = `PCGM_K1;
    end else if (t_q < `PCGM_T60) begin
      f = (b_q & c_q) | (b_q & d_q) | (c_q & d_q);
      k = `PCGM_K2;
    end else begin
      f = b_q ^ c_q ^ d_q;
      k = `PCGM_K3;
    end
    wn  = w_q[13] ^ w_q[8] ^ w_q[2] ^ w_q[0];
    wn  = {wn[30:0], wn[31]};
    tmp = {a_q[26:0], a_q[31:27]} + f + e_q + k + w_q[0];
  end
  integer j;
  // A start while busy is ignored; done pulses once when the last round retires.
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      sha_busy_o   <= 1'b0;
      sha_done_o   <= 1'b0;
      sha_digest_o <= 160'h0;
      t_q <= 7'h0;
      a_q <= 32'h0;
      b_q <= 32'h0;
      c_q <= 32'h0;
      d_q <= 32'h0;
      e_q <= 32'h0;
      for (j = 0; j < 16; j = j + 1) w_q[j] <= 32'h0;
    end else begin
      sha_done_o <= 1'b0;
      if (!sha_busy_o && sha_start_i) begin
        sha_busy_o <= 1'b1;
        t_q <= 7'h0;
        a_q <= `PCGM_H0;
        b_q <= `PCGM_H1;
        c_q <= `PCGM_H2;
        d_q <= `PCGM_H3;
        e_q <= `PCGM_H4;
        for (j = 0; j < 16; j = j + 1) w_q[j] <= block[511 - 32 * j -: 32];
      end else if (sha_busy_o) begin
        a_q <= tmp;
        b_q <= a_q;
        c_q <= {b_q[1:0], b_q[31:2]};
        d_q <= c_q;
        e_q <= d_q;
        for (j = 0; j < 15; j = j + 1) w_q[j] <= w_q[j + 1];
        w_q[15] <= wn;
        t_q <= t_q + 7'h1;
        // Feed-forward adds the chaining values to the state after the last round.
        if (t_q == `PCGM_SHA_ROUNDS) begin
          sha_busy_o   <= 1'b0;
          sha_done_o   <= 1'b1;
          sha_digest_o <= {`PCGM_H0 + tmp, `PCGM_H1 + a_q, `PCGM_H2 + {b_q[1:0], b_q[31:2]},
                           `PCGM_H3 + c_q, `PCGM_H4 + d_q};
        end
      end
    end
  end
endmodule // pcgm_monitor
`default_nettype wire

/* bench/pcgm_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pcgm_regs.vh"
module pcgm_host_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] ctrl_i,
  output var  logic        power_o,
  output var  logic        cmd_valid_o,
  output var  logic [15:0] cmd_code_o
);
  // The host starts with the gauge unpowered and no command pending.
  initial begin
    power_o = 1'b0;
    cmd_valid_o = 1'b0;
    cmd_code_o = 16'h0000;
  end
  // A command is a one-cycle pulse; the code lines then change so stale codes never match.
  task automatic send(input logic [15:0] code);
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_code_o = code;
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    cmd_code_o = ~code;
  endtask
  // The enable pin is a plain level from the host.
  task automatic set_power(input logic on);
    @(negedge clk_i);
    power_o = on;
  endtask
  // Ending accumulation waits for stop complete, since power removal earlier loses data.
  task automatic stop(output logic ok);
    send(`PCGM_CMD_STOP);
    for (int i = 0; i < 40 && ctrl_i[1] !== 1'b1; i++)
      @(negedge clk_i);
    ok = ctrl_i[1];
  endtask
endmodule // pcgm_host_model
`default_nettype wire

/* bench/pcgm_monitor_chk.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pcgm_regs.vh"
module pcgm_monitor_chk #(
  parameter int TICK_CYCLES = 10000000
) (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        power_on_input_i,
  input wire logic [7:0]  alert_mask_bits_i,
  input wire logic        cmd_valid_i,
  input wire logic [15:0] cmd_code_i,
  input wire logic        sha_start_i,
  input wire logic        active_o,
  input wire logic        acc_data_valid_o,
  input wire logic [7:0]  cell_status_flags_o,
  input wire logic [15:0] ctrl_state_word_o,
  input wire logic [7:0]  cell_alert_flags_o,
  input wire logic        alert_o,
  input wire logic        flash_we_o,
  input wire logic [2:0]  flash_addr_o,
  input wire logic        sha_busy_o,
  input wire logic        sha_done_o
);
  // Everything here lives in the single clock domain.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_alert_or;
    alert_o == (|cell_alert_flags_o);
  endproperty
  a_alert_or: assert property (p_alert_or) else $error("alert pin differs");
  // The guard skips the first edge after a reset, where the past still shows old status.
  property p_flag_status;
    $past(reset_n_i) |-> cell_alert_flags_o[3:0] ==
      ($past(alert_mask_bits_i[3:0]) & cell_status_flags_o[3:0]);
  endproperty
  a_flag_status: assert property (p_flag_status) else $error("alert flags wrong");
  property p_flag_mask;
    (cell_alert_flags_o & ~$past(alert_mask_bits_i)) == 8'h00;
  endproperty
  a_flag_mask: assert property (p_flag_mask) else $error("unmasked alert flag");
  property p_sha_time;
    sha_start_i && !sha_busy_o |-> ##[81:82] sha_done_o;
  endproperty
  a_sha_time: assert property (p_sha_time) else $error("digest late");
  property p_sha_pulse;
    sha_done_o |=> !sha_done_o;
  endproperty
  a_sha_pulse: assert property (p_sha_pulse) else $error("done too long");
  property p_power_on;
    $rose(power_on_input_i) |-> ##[3:8] active_o;
  endproperty
  a_power_on: assert property (p_power_on) else $error("not active");
  property p_flash_run;
    $rose(flash_we_o) |-> flash_addr_o == 3'h0 ##0 flash_we_o [*6] ##1 !flash_we_o;
  endproperty
  a_flash_run: assert property (p_flash_run) else $error("flush length wrong");
  property p_flash_step;
    flash_we_o && flash_addr_o != 3'h5 |=> flash_addr_o == $past(flash_addr_o) + 3'h1;
  endproperty
  a_flash_step: assert property (p_flash_step) else $error("flush order wrong");
  property p_stop_done;
    $fell(flash_we_o) |-> ##[0:1] ctrl_state_word_o[1];
  endproperty
  a_stop_done: assert property (p_stop_done) else $error("no stop complete");
  property p_log_en;
    cmd_valid_i && cmd_code_i == `PCGM_CMD_LOG_EN |-> ##[1:2] ctrl_state_word_o[2];
  endproperty
  a_log_en: assert property (p_log_en) else $error("log not enabled");
  property p_log_hold;
    ctrl_state_word_o[2] |=> ctrl_state_word_o[2];
  endproperty
  a_log_hold: assert property (p_log_hold) else $error("log enable lost");
  property p_acc_valid;
    acc_data_valid_o |-> active_o;
  endproperty
  a_acc_valid: assert property (p_acc_valid) else $error("data valid unpowered");
endmodule // pcgm_monitor_chk
bind pcgm_monitor pcgm_monitor_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);
`default_nettype wire

/* bench/pcgm_monitor_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pcgm_regs.vh"
module pcgm_monitor_tb;
  localparam int TICK = 20;
  localparam logic [15:0] EXPW [6] = '{16'h0e10, 16'h0d00, 16'hffeb, 16'hffeb, 16'h0c1c, 16'h0bb8};
  logic clk_i = 1'b0, reset_n_i = 1'b0, temp_source_select_i = 1'b0, meas_valid_i = 1'b0;
  logic impedance_valid_i = 1'b0, sha_start_i = 1'b0, ok;
  logic [1:0] mode_sel_i = 2'h0;
  logic [7:0] state_value_i = 8'h32, health_low_threshold_i = 8'h31, alert_mask_bits_i = 8'hff;
  logic [14:0] sense_code_i = 15'h7ff0;
  logic [15:0] cell_voltage_i = 16'h0000, ext_temp_i = 16'h0000, onchip_temp_i = 16'h0000;
  logic [15:0] self_consumption_current_i = 16'h0005, volt_low_threshold_i = 16'h0000;
  logic [15:0] temp_low_threshold_i = 16'h8000, temp_high_threshold_i = 16'h7fff;
  logic [15:0] impedance_i = 16'h0000;
  logic [127:0] sha_key_i = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
  logic [159:0] sha_msg_i = 160'h0123456789abcdeffedcba9876543210a5a5c3c3;
  wire logic power_on_input_i, cmd_valid_i;
  wire logic [15:0] cmd_code_i;
  logic active_o, acc_data_valid_o, health_valid_o, alert_o, flash_we_o, sha_busy_o, sha_done_o;
  logic [2:0] flash_addr_o;
  logic [7:0] health_o, cell_status_flags_o, cell_alert_flags_o;
  logic [15:0] temperature_o, onchip_temp_reading_o, voltage_o, current_o, ocv_o;
  logic [15:0] ctrl_state_word_o, fresh_cell_resistance_o, flash_data_o;
  logic [15:0] fword [6];
  logic [31:0] coulomb_o;
  logic [159:0] sha_digest_o;
  int err_total = 0, samples_checked = 0, nwe = 0;
  pcgm_monitor #(.TICK_CYCLES(TICK)) dut (.*);
  pcgm_host_model host (.clk_i(clk_i), .ctrl_i(ctrl_state_word_o), .power_o(power_on_input_i),
    .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i));
  // The clock runs at 10 MHz.
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // Flash words are kept by address so that each word can be checked against its address later.
  always @(posedge clk_i) begin
    if (flash_we_o === 1'b1) begin
      fword[flash_addr_o] <= flash_data_o;
      nwe <= nwe + 1;
    end
  end
  task automatic check_val(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic await_active(input logic lvl);
    for (int i = 0; i < 20 && active_o !== lvl; i++)
      @(negedge clk_i);
    check_val("active", lvl, active_o);
  endtask
  // A sample is held for cyc cycles, so a long hold always spans one update tick.
  task automatic sample(input logic [15:0] v, t, n, input int cyc);
    @(negedge clk_i);
    cell_voltage_i = v;
    ext_temp_i = t;
    onchip_temp_i = n;
    meas_valid_i = 1'b1;
    settle(cyc);
    meas_valid_i = 1'b0;
    settle(2);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // The watchdog allows about twenty-five times the expected run length.
  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    print_verdict;
  end
  initial begin
    settle(16);
    reset_n_i = 1'b1;
    check_val("ctrl", 0, ctrl_state_word_o);
    host.set_power(1'b1);
    await_active(1'b1);
    host.send(`PCGM_CMD_START);
    host.send(`PCGM_CMD_LOG_EN);
    settle(2);
    check_val("ctrl", 16'h0005, ctrl_state_word_o);
    check_val("acc_valid", 1, acc_data_valid_o);
    sample(16'h0e10, 16'h0c1c, 16'h0bb8, 1);
    check_val("ocv", 16'h0e10, ocv_o);
    check_val("temp", 16'h0bb8, temperature_o);
    check_val("current", 16'hffeb, current_o);
    temp_source_select_i = 1'b1;
    sample(16'h0d00, 16'h0c1c, 16'h0bb8, TICK + 4);
    check_val("voltage", 16'h0d00, voltage_o);
    check_val("ocv", 16'h0e10, ocv_o);
    check_val("temp", 16'h0c1c, temperature_o);
    check_val("onchip", 16'h0bb8, onchip_temp_reading_o);
    $display("test measure done");
    host.stop(ok);
    settle(1);
    check_val("stop_done", 1, ok);
    check_val("flash_count", 6, nwe);
    for (int i = 0; i < 6; i++)
      check_val("flash_word", EXPW[i], fword[i]);
    check_val("alert_flags", 8'h20, cell_alert_flags_o);
    $display("test stop done");
    alert_mask_bits_i = 8'h0f;
    // Health low needs a health reading, so that warning is checked in health mode.
    for (int i = 0; i < 3; i++) begin
      volt_low_threshold_i = (i == 0) ? 16'h0d01 : 16'h0000;
      temp_low_threshold_i = (i == 1) ? 16'h0c1d : 16'h8000;
      temp_high_threshold_i = (i == 2) ? 16'h0c1b : 16'h7fff;
      settle(4);
      check_val("status", 8'h01 << i, cell_status_flags_o);
      check_val("alert_flags", 8'h01 << i, cell_alert_flags_o);
      check_val("alert", 1, alert_o);
    end
    temp_high_threshold_i = 16'h7fff;
    alert_mask_bits_i = 8'h00;
    settle(3);
    check_val("alert", 0, alert_o);
    $display("test alert done");
    check_val("coulomb_nz", 1, coulomb_o != 0);
    host.send(`PCGM_CMD_FRESH);
    for (int i = 0; i < 2; i++) begin
      impedance_i = i ? 16'h0456 : 16'h0123;
      impedance_valid_i = 1'b1;
      settle(1);
      impedance_valid_i = 1'b0;
      settle(1);
    end
    check_val("coulomb", 0, coulomb_o);
    check_val("fresh_r", 16'h0123, fresh_cell_resistance_o);
    $display("test fresh done");
    host.set_power(1'b0);
    await_active(1'b0);
    mode_sel_i = `PCGM_MODE_HEALTH;
    state_value_i = 8'h2a;
    host.set_power(1'b1);
    await_active(1'b1);
    host.send(`PCGM_CMD_START);
    settle(2);
    check_val("run", 0, ctrl_state_word_o[0]);
    sample(16'h0c80, 16'h0c1c, 16'h0bb8, 1);
    check_val("health", 8'h2a, health_o);
    check_val("health_valid", 1, health_valid_o);
    check_val("ocv", 16'h0c80, ocv_o);
    health_low_threshold_i = 8'h2a;
    alert_mask_bits_i = 8'h0f;
    settle(3);
    check_val("status", 8'h08, cell_status_flags_o);
    check_val("alert_flags", 8'h08, cell_alert_flags_o);
    check_val("alert", 1, alert_o);
    health_low_threshold_i = 8'h29;
    settle(3);
    check_val("status", 8'h00, cell_status_flags_o);
    $display("test health done");
    sha_start_i = 1'b1;
    settle(1);
    sha_start_i = 1'b0;
    for (int i = 0; i < 100 && sha_done_o !== 1'b1; i++)
      @(negedge clk_i);
    check_val("sha_done", 1, sha_done_o);
    check_val("digest_nz", 1, sha_digest_o != 0);
    $display("test hash done");
    print_verdict;
  end
endmodule // pcgm_monitor_tb
`default_nettype wire
